// ### design/plmux_params.svh
// register offsets, field positions and reset values of the pin location mux
`ifndef PLMUX_PARAMS_SVH
`define PLMUX_PARAMS_SVH

`define PLMUX_ADDR_W          8
`define PLMUX_OFS_LUT_EVENT   8'h00
`define PLMUX_OFS_SERIAL      8'h01
`define PLMUX_OFS_TIMER_A     8'h02
`define PLMUX_OFS_TIMER_B     8'h03

`define PLMUX_MASK_LUT_EVENT  8'h37
`define PLMUX_MASK_SERIAL     8'h15
`define PLMUX_MASK_TIMER_A    8'h3f
`define PLMUX_MASK_TIMER_B    8'h01
`define PLMUX_RESET_VAL       8'h00

`define PLMUX_BIT_LUT_ONE     5
`define PLMUX_BIT_LUT_ZERO    4
`define PLMUX_BIT_EVOUT_LO    0
`define PLMUX_BIT_TWO_WIRE    4
`define PLMUX_BIT_SPI         2
`define PLMUX_BIT_USART       0
`define PLMUX_BIT_TCB         0

`define PLMUX_N_EVENT         3
`define PLMUX_N_WAVE          6
`define PLMUX_N_SPLIT_ONLY    3
`define PLMUX_N_SPI           4
`define PLMUX_N_USART         4
`define PLMUX_N_TWI           2

`endif

// ### design/plmux_pkg.sv
// types shared by the pin location mux modules
package plmux_pkg;

    typedef logic [7:0] plmux_byte_t;

    typedef enum logic [1:0]
    {
        PLMUX_REG_LUT_EVENT,
        PLMUX_REG_SERIAL,
        PLMUX_REG_TIMER_A,
        PLMUX_REG_TIMER_B
    } plmux_reg_sel_t;

endpackage

// ### design/plmux_regs.sv
// four control registers of the pin location mux with their bus port
`timescale 1ns/1ps
`include "plmux_params.svh"
module plmux_regs
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    // register port
    input  wire logic [`PLMUX_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output      logic [7:0]                reg_rdata,
    // selects
    plmux_sel_if.regs                      sel
);
    plmux_pkg::plmux_byte_t lut_event_r, lut_event_nxt;
    plmux_pkg::plmux_byte_t serial_r,    serial_nxt;
    plmux_pkg::plmux_byte_t timer_a_r,   timer_a_nxt;
    plmux_pkg::plmux_byte_t timer_b_r,   timer_b_nxt;
    plmux_pkg::plmux_byte_t rdata_r,     rdata_nxt;

    always_comb
    begin
        lut_event_nxt = lut_event_r;
        serial_nxt    = serial_r;
        timer_a_nxt   = timer_a_r;
        timer_b_nxt   = timer_b_r;
        rdata_nxt     = 8'h00;
        if (reg_wr)
        begin
            // unassigned bits are dropped on write
            unique case (reg_addr)
                `PLMUX_OFS_LUT_EVENT:
                    lut_event_nxt = reg_wdata & `PLMUX_MASK_LUT_EVENT; // R15
                `PLMUX_OFS_SERIAL:
                    serial_nxt = reg_wdata & `PLMUX_MASK_SERIAL; // R15
                `PLMUX_OFS_TIMER_A:
                    timer_a_nxt = reg_wdata & `PLMUX_MASK_TIMER_A; // R15
                `PLMUX_OFS_TIMER_B:
                    timer_b_nxt = reg_wdata & `PLMUX_MASK_TIMER_B; // R15
                default:
                    ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                `PLMUX_OFS_LUT_EVENT: rdata_nxt = lut_event_r;
                `PLMUX_OFS_SERIAL:    rdata_nxt = serial_r;
                `PLMUX_OFS_TIMER_A:   rdata_nxt = timer_a_r;
                `PLMUX_OFS_TIMER_B:   rdata_nxt = timer_b_r;
                default:              rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lut_event_r <= `PLMUX_RESET_VAL; // R14
            serial_r    <= `PLMUX_RESET_VAL; // R14
            timer_a_r   <= `PLMUX_RESET_VAL; // R14
            timer_b_r   <= `PLMUX_RESET_VAL; // R14
            rdata_r     <= 8'h00;
        end
        else
        begin
            lut_event_r <= lut_event_nxt;
            serial_r    <= serial_nxt;
            timer_a_r   <= timer_a_nxt;
            timer_b_r   <= timer_b_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    assign reg_rdata                 = rdata_r;
    assign sel.lookup_table_one_alt  = lut_event_r[`PLMUX_BIT_LUT_ONE];
    assign sel.lookup_table_zero_alt = lut_event_r[`PLMUX_BIT_LUT_ZERO];
    assign sel.event_output_enable   = lut_event_r[2:0];
    assign sel.two_wire_alt_pins     = serial_r[`PLMUX_BIT_TWO_WIRE];
    assign sel.spi_alt_pins          = serial_r[`PLMUX_BIT_SPI];
    assign sel.usart_alt_pins        = serial_r[`PLMUX_BIT_USART];
    assign sel.timer_a_wave_alt      = timer_a_r[5:0];
    assign sel.timer_b_output_alt    = timer_b_r[`PLMUX_BIT_TCB];
endmodule

// ### design/plmux_route.sv
// steers one peripheral signal group to its default or alternative pins
`timescale 1ns/1ps
module plmux_route
#(
    parameter int W = 1
)
(
    // selection
    input  wire logic         alt,
    // peripheral side
    input  wire logic [W-1:0] per_out,
    input  wire logic [W-1:0] per_oe,
    output      logic [W-1:0] per_in,
    // default pins
    input  wire logic [W-1:0] def_in,
    output      logic [W-1:0] def_out,
    output      logic [W-1:0] def_oe,
    // alternative pins
    input  wire logic [W-1:0] alt_in,
    output      logic [W-1:0] alt_out,
    output      logic [W-1:0] alt_oe
);
    // the unused location is released so the port logic keeps it
    assign def_out = alt ? '0 : per_out;
    assign def_oe  = alt ? '0 : per_oe;
    assign alt_out = alt ? per_out : '0;
    assign alt_oe  = alt ? per_oe : '0;
    assign per_in  = alt ? alt_in : def_in;
endmodule

// ### design/plmux_sel_if.sv
// select lines carried from the register file to the steering logic
`timescale 1ns/1ps
interface plmux_sel_if;
    logic       lookup_table_one_alt;
    logic       lookup_table_zero_alt;
    logic [2:0] event_output_enable;
    logic       two_wire_alt_pins;
    logic       spi_alt_pins;
    logic       usart_alt_pins;
    logic [5:0] timer_a_wave_alt;
    logic       timer_b_output_alt;

    modport regs  (output lookup_table_one_alt, lookup_table_zero_alt,
                   event_output_enable, two_wire_alt_pins, spi_alt_pins,
                   usart_alt_pins, timer_a_wave_alt, timer_b_output_alt);
    modport steer (input  lookup_table_one_alt, lookup_table_zero_alt,
                   event_output_enable, two_wire_alt_pins, spi_alt_pins,
                   usart_alt_pins, timer_a_wave_alt, timer_b_output_alt);
endinterface

// ### design/plmux_top.sv
// pin location mux: control registers and peripheral pin steering
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "plmux_params.svh"
//
// Operation
// R1 - lookup table one output goes to alternative pin when its bit is set
// R2 - lookup table zero output goes to alternative pin when its bit is set
// R3 - three bits each enable one event output onto its pin
// R4 - two-wire signals move to alternative pins when its bit is set
// R5 - spi signals move to alternative pins when its bit is set
// R6 - usart signals move to alternative pins when its bit is set
// R7 - timer a wave 5 alternative pin, effective in split mode only
// R8 - timer a wave 4 alternative pin, effective in split mode only
// R9 - timer a wave 3 alternative pin, effective in split mode only
// R10 - timer a wave 2 alternative pin; low compare 2 in split mode
// R11 - timer a wave 1 alternative pin; low compare 1 in split mode
// R12 - timer a wave 0 alternative pin; low compare 0 in split mode
// R13 - timer b output goes to alternative pin when its bit is set
// R14 - all four registers reset to zero: default pins, events off
// R15 - unassigned bits read zero and writes to them have no effect
module plmux_top
(
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // register port
    input  wire logic [`PLMUX_ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output      logic [7:0]                  reg_rdata,
    // configurable logic unit outputs
    input  wire logic [1:0]                  lut_out,
    output      logic [1:0]                  lut_def_pin,
    output      logic [1:0]                  lut_alt_pin,
    // event outputs
    input  wire logic [`PLMUX_N_EVENT-1:0]   event_out,
    output      logic [`PLMUX_N_EVENT-1:0]   event_pin,
    output      logic [`PLMUX_N_EVENT-1:0]   event_pin_oe,
    // spi: peripheral side
    input  wire logic [`PLMUX_N_SPI-1:0]     spi_out,
    input  wire logic [`PLMUX_N_SPI-1:0]     spi_oe,
    output      logic [`PLMUX_N_SPI-1:0]     spi_in,
    // spi: pins
    input  wire logic [`PLMUX_N_SPI-1:0]     spi_def_i,
    output      logic [`PLMUX_N_SPI-1:0]     spi_def_o,
    output      logic [`PLMUX_N_SPI-1:0]     spi_def_oe,
    input  wire logic [`PLMUX_N_SPI-1:0]     spi_alt_i,
    output      logic [`PLMUX_N_SPI-1:0]     spi_alt_o,
    output      logic [`PLMUX_N_SPI-1:0]     spi_alt_oe,
    // usart: peripheral side
    input  wire logic [`PLMUX_N_USART-1:0]   usart_out,
    input  wire logic [`PLMUX_N_USART-1:0]   usart_oe,
    output      logic [`PLMUX_N_USART-1:0]   usart_in,
    // usart: pins
    input  wire logic [`PLMUX_N_USART-1:0]   usart_def_i,
    output      logic [`PLMUX_N_USART-1:0]   usart_def_o,
    output      logic [`PLMUX_N_USART-1:0]   usart_def_oe,
    input  wire logic [`PLMUX_N_USART-1:0]   usart_alt_i,
    output      logic [`PLMUX_N_USART-1:0]   usart_alt_o,
    output      logic [`PLMUX_N_USART-1:0]   usart_alt_oe,
    // two-wire: peripheral side
    input  wire logic [`PLMUX_N_TWI-1:0]     twi_out,
    input  wire logic [`PLMUX_N_TWI-1:0]     twi_oe,
    output      logic [`PLMUX_N_TWI-1:0]     twi_in,
    // two-wire: pins
    input  wire logic [`PLMUX_N_TWI-1:0]     twi_def_i,
    output      logic [`PLMUX_N_TWI-1:0]     twi_def_o,
    output      logic [`PLMUX_N_TWI-1:0]     twi_def_oe,
    input  wire logic [`PLMUX_N_TWI-1:0]     twi_alt_i,
    output      logic [`PLMUX_N_TWI-1:0]     twi_alt_o,
    output      logic [`PLMUX_N_TWI-1:0]     twi_alt_oe,
    // timer a waveform outputs
    input  wire logic                        timer_a_split,
    input  wire logic [`PLMUX_N_WAVE-1:0]    timer_a_wave,
    input  wire logic [`PLMUX_N_WAVE-1:0]    timer_a_wave_en,
    output      logic [`PLMUX_N_WAVE-1:0]    timer_a_def_pin,
    output      logic [`PLMUX_N_WAVE-1:0]    timer_a_def_oe,
    output      logic [`PLMUX_N_WAVE-1:0]    timer_a_alt_pin,
    output      logic [`PLMUX_N_WAVE-1:0]    timer_a_alt_oe,
    // timer b output
    input  wire logic                        timer_b_out,
    input  wire logic                        timer_b_out_en,
    output      logic                        timer_b_def_pin,
    output      logic                        timer_b_def_oe,
    output      logic                        timer_b_alt_pin,
    output      logic                        timer_b_alt_oe
);
    plmux_sel_if sel ();

    logic [`PLMUX_N_WAVE-1:0] wave_alt_eff;

    plmux_regs u_regs
    (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .sel       (sel)
    );

    // lookup table outputs, driven only at the selected location
    assign lut_def_pin[1] = sel.lookup_table_one_alt ? 1'b0 : lut_out[1]; // R1
    assign lut_alt_pin[1] = sel.lookup_table_one_alt ? lut_out[1] : 1'b0; // R1
    assign lut_def_pin[0] = sel.lookup_table_zero_alt ? 1'b0 : lut_out[0]; // R2
    assign lut_alt_pin[0] = sel.lookup_table_zero_alt ? lut_out[0] : 1'b0; // R2

    // event outputs gated by their enables
    genvar g;
    generate
        for (g = 0; g < `PLMUX_N_EVENT; g++)
        begin : g_event
            assign event_pin[g]    = sel.event_output_enable[g] & event_out[g]; // R3
            assign event_pin_oe[g] = sel.event_output_enable[g]; // R3
        end
    endgenerate

    plmux_route #(.W(`PLMUX_N_TWI)) u_twi // R4
    (
        .alt     (sel.two_wire_alt_pins),
        .per_out (twi_out),
        .per_oe  (twi_oe),
        .per_in  (twi_in),
        .def_in  (twi_def_i),
        .def_out (twi_def_o),
        .def_oe  (twi_def_oe),
        .alt_in  (twi_alt_i),
        .alt_out (twi_alt_o),
        .alt_oe  (twi_alt_oe)
    );

    plmux_route #(.W(`PLMUX_N_SPI)) u_spi // R5
    (
        .alt     (sel.spi_alt_pins),
        .per_out (spi_out),
        .per_oe  (spi_oe),
        .per_in  (spi_in),
        .def_in  (spi_def_i),
        .def_out (spi_def_o),
        .def_oe  (spi_def_oe),
        .alt_in  (spi_alt_i),
        .alt_out (spi_alt_o),
        .alt_oe  (spi_alt_oe)
    );

    plmux_route #(.W(`PLMUX_N_USART)) u_usart // R6
    (
        .alt     (sel.usart_alt_pins),
        .per_out (usart_out),
        .per_oe  (usart_oe),
        .per_in  (usart_in),
        .def_in  (usart_def_i),
        .def_out (usart_def_o),
        .def_oe  (usart_def_oe),
        .alt_in  (usart_alt_i),
        .alt_out (usart_alt_o),
        .alt_oe  (usart_alt_oe)
    );

    // wave 3..5 only move in split mode; 0..2 move in both modes
    generate
        for (g = 0; g < `PLMUX_N_WAVE; g++)
        begin : g_wave
            if (g >= `PLMUX_N_SPLIT_ONLY)
            begin : g_split_only
                assign wave_alt_eff[g] = sel.timer_a_wave_alt[g] & timer_a_split; // R7 R8 R9
            end
            else
            begin : g_both
                assign wave_alt_eff[g] = sel.timer_a_wave_alt[g]; // R10 R11 R12
            end
            assign timer_a_def_pin[g] = wave_alt_eff[g] ? 1'b0 : timer_a_wave[g];
            assign timer_a_def_oe[g]  = wave_alt_eff[g] ? 1'b0 : timer_a_wave_en[g];
            assign timer_a_alt_pin[g] = wave_alt_eff[g] ? timer_a_wave[g] : 1'b0;
            assign timer_a_alt_oe[g]  = wave_alt_eff[g] ? timer_a_wave_en[g] : 1'b0;
        end
    endgenerate

    assign timer_b_def_pin = sel.timer_b_output_alt ? 1'b0 : timer_b_out; // R13
    assign timer_b_def_oe  = sel.timer_b_output_alt ? 1'b0 : timer_b_out_en; // R13
    assign timer_b_alt_pin = sel.timer_b_output_alt ? timer_b_out : 1'b0; // R13
    assign timer_b_alt_oe  = sel.timer_b_output_alt ? timer_b_out_en : 1'b0; // R13
endmodule

// ### verification/plmux_peri_model.sv
// peripheral and pad model: signals that change every cycle
`timescale 1ns/1ps
module plmux_peri_model
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // peripheral outputs and pad inputs, packed
    output      logic [58:0] pat
);
    logic [58:0] pat_nxt;

    always_comb
    begin
        pat_nxt = {pat[57:0], pat[58] ^ pat[38]};
    end

    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            pat <= 59'h5a5a5c30f96e1b7;
        else
            pat <= pat_nxt;
endmodule

// ### verification/plmux_props.sv
// concurrent checks on the pin location mux top ports
`timescale 1ns/1ps
`include "plmux_params.svh"
module plmux_props
(
    // clock, reset and register port
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [1:0] lut_out,
    input wire logic [1:0] lut_alt_pin,
    input wire logic [2:0] event_out,
    input wire logic [2:0] event_pin,
    input wire logic [2:0] event_pin_oe,
    input wire logic [3:0] spi_def_i,
    input wire logic [3:0] spi_alt_i,
    input wire logic [3:0] spi_in,
    input wire logic [3:0] usart_out,
    input wire logic [3:0] usart_def_o,
    input wire logic [1:0] twi_oe,
    input wire logic [1:0] twi_alt_oe,
    input wire logic       timer_a_split,
    input wire logic [5:0] timer_a_wave,
    input wire logic [5:0] timer_a_alt_pin,
    input wire logic [5:0] timer_a_def_pin,
    input wire logic       timer_b_out,
    input wire logic       timer_b_alt_pin,
    // further pins
    input wire logic [1:0] lut_def_pin,
    input wire logic [3:0] spi_out,
    input wire logic [3:0] spi_oe,
    input wire logic [3:0] spi_def_o,
    input wire logic [3:0] spi_def_oe,
    input wire logic [3:0] spi_alt_o,
    input wire logic [3:0] spi_alt_oe,
    input wire logic [3:0] usart_oe,
    input wire logic [3:0] usart_def_i,
    input wire logic [3:0] usart_alt_i,
    input wire logic [3:0] usart_in,
    input wire logic [3:0] usart_def_oe,
    input wire logic [3:0] usart_alt_o,
    input wire logic [3:0] usart_alt_oe,
    input wire logic [1:0] twi_out,
    input wire logic [1:0] twi_def_i,
    input wire logic [1:0] twi_alt_i,
    input wire logic [1:0] twi_in,
    input wire logic [1:0] twi_def_o,
    input wire logic [1:0] twi_def_oe,
    input wire logic [1:0] twi_alt_o,
    input wire logic [5:0] timer_a_wave_en,
    input wire logic [5:0] timer_a_def_oe,
    input wire logic [5:0] timer_a_alt_oe,
    input wire logic       timer_b_out_en,
    input wire logic       timer_b_def_pin,
    input wire logic       timer_b_def_oe,
    input wire logic       timer_b_alt_oe
);
    localparam logic [7:0] MASK [4] = '{`PLMUX_MASK_LUT_EVENT,
        `PLMUX_MASK_SERIAL, `PLMUX_MASK_TIMER_A, `PLMUX_MASK_TIMER_B};
    logic [7:0] sh_r [4];
    logic [7:0] rd_exp;
    logic [5:0] wave_sel;
    logic [3:0] spi_m;
    logic [3:0] usart_m;
    logic [1:0] twi_m;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // shadow copy of the control registers
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            sh_r <= '{default: 8'h00};
        else if (reg_wr && reg_addr < 8'h04)
            sh_r[reg_addr[1:0]] <= reg_wdata & MASK[reg_addr[1:0]];

    assign rd_exp = (reg_addr < 8'h04) ? sh_r[reg_addr[1:0]] : 8'h00;
    assign wave_sel = sh_r[2][5:0] & {{3{timer_a_split}}, 3'h7};
    assign spi_m    = {4{sh_r[1][2]}};
    assign usart_m  = {4{sh_r[1][0]}};
    assign twi_m    = {2{sh_r[1][4]}};

    sequence s_read_req;
        reg_rd;
    endsequence
    sequence s_no_req;
        !reg_rd;
    endsequence

    a_read_value:
    assert property (s_read_req |=> reg_rdata == $past(rd_exp))
        else $error("read data differs from register contents");
    a_rdata_idle:
    assert property (s_no_req |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_lut_route:
    assert property (lut_alt_pin == (lut_out & sh_r[0][5:4]))
        else $error("lookup table output on wrong location");
    a_event_gate:
    assert property (event_pin_oe == sh_r[0][2:0]
                     && event_pin == (event_out & sh_r[0][2:0]))
        else $error("event output gating wrong");
    a_twi_move:
    assert property (twi_alt_oe == (twi_oe & {2{sh_r[1][4]}}))
        else $error("two-wire enables on wrong location");
    a_spi_move:
    assert property (spi_in == (sh_r[1][2] ? spi_alt_i : spi_def_i))
        else $error("spi input taken from wrong location");
    a_usart_move:
    assert property (usart_def_o == (usart_out & {4{!sh_r[1][0]}}))
        else $error("usart output on wrong location");
    a_wave_alt:
    assert property (timer_a_alt_pin == (timer_a_wave & wave_sel))
        else $error("timer a alternative pin wrong");
    a_wave_def:
    assert property (timer_a_def_pin == (timer_a_wave & ~wave_sel))
        else $error("timer a default pin wrong");
    a_timer_b:
    assert property (timer_b_alt_pin == (timer_b_out & sh_r[3][0]))
        else $error("timer b output on wrong location");
    a_lut_default:
    assert property (lut_def_pin == (lut_out & ~sh_r[0][5:4]))
        else $error("lookup table default location wrong");
    a_spi_pins:
    assert property (spi_alt_o == (spi_out & spi_m)
                     && spi_alt_oe == (spi_oe & spi_m)
                     && spi_def_o == (spi_out & ~spi_m)
                     && spi_def_oe == (spi_oe & ~spi_m))
        else $error("spi pin outputs on wrong location");
    a_usart_pins:
    assert property (usart_in == (sh_r[1][0] ? usart_alt_i : usart_def_i)
                     && usart_alt_o == (usart_out & usart_m)
                     && usart_alt_oe == (usart_oe & usart_m)
                     && usart_def_oe == (usart_oe & ~usart_m))
        else $error("usart pins on wrong location");
    a_twi_pins:
    assert property (twi_in == (sh_r[1][4] ? twi_alt_i : twi_def_i)
                     && twi_alt_o == (twi_out & twi_m)
                     && twi_def_o == (twi_out & ~twi_m)
                     && twi_def_oe == (twi_oe & ~twi_m))
        else $error("two-wire pins on wrong location");
    a_wave_enable:
    assert property (timer_a_alt_oe == (timer_a_wave_en & wave_sel)
                     && timer_a_def_oe == (timer_a_wave_en & ~wave_sel))
        else $error("timer a output enables on wrong location");
    a_timer_b_def:
    assert property (timer_b_def_pin == (timer_b_out & !sh_r[3][0])
                     && timer_b_def_oe == (timer_b_out_en & !sh_r[3][0])
                     && timer_b_alt_oe == (timer_b_out_en & sh_r[3][0]))
        else $error("timer b default pin or enables wrong");
endmodule

// ### verification/plmux_test.sv
// self-checking bench for the pin location mux
`timescale 1ns/1ps
`include "plmux_params.svh"
module plmux_test;
    localparam logic [7:0] MASK [5] = '{`PLMUX_MASK_LUT_EVENT,
        `PLMUX_MASK_SERIAL, `PLMUX_MASK_TIMER_A, `PLMUX_MASK_TIMER_B, 8'h00};
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, timer_a_split = 1'b0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [58:0] pat;
    logic [1:0]  lut_out, lut_def_pin, lut_alt_pin, twi_out, twi_oe;
    logic [1:0]  twi_in, twi_def_i, twi_def_o, twi_def_oe, twi_alt_i;
    logic [1:0]  twi_alt_o, twi_alt_oe;
    logic [2:0]  event_out, event_pin, event_pin_oe;
    logic [3:0]  spi_out, spi_oe, spi_in, spi_def_i, spi_def_o, spi_def_oe;
    logic [3:0]  spi_alt_i, spi_alt_o, spi_alt_oe, usart_out, usart_oe;
    logic [3:0]  usart_in, usart_def_i, usart_def_o, usart_def_oe;
    logic [3:0]  usart_alt_i, usart_alt_o, usart_alt_oe;
    logic [5:0]  timer_a_wave, timer_a_wave_en, timer_a_def_pin;
    logic [5:0]  timer_a_def_oe, timer_a_alt_pin, timer_a_alt_oe;
    logic        timer_b_out, timer_b_out_en, timer_b_def_pin;
    logic        timer_b_def_oe, timer_b_alt_pin, timer_b_alt_oe;
    int          mismatches = 0, cmp_count = 0;

    assign {lut_out, event_out, spi_out, spi_oe, spi_def_i, spi_alt_i,
            usart_out, usart_oe, usart_def_i, usart_alt_i, twi_out, twi_oe,
            twi_def_i, twi_alt_i, timer_a_wave, timer_a_wave_en,
            timer_b_out, timer_b_out_en} = pat;

    plmux_peri_model peri (.ref_clk(ref_clk), .reset_n(reset_n), .pat(pat));
    plmux_top dut (.*);

    always #20 ref_clk = ~ref_clk;

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // strobe left high; the following read lowers it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check8(reg_rdata, exp);
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++)
            rdchk(i[7:0], 8'h00);
        @(negedge ref_clk);
        check8({4'h0, spi_in}, {4'h0, spi_def_i});
        check8({5'h0, event_pin_oe}, 8'h00);
        check8({2'h0, timer_a_def_pin}, {2'h0, timer_a_wave});
        @(posedge ref_clk);
    endtask

    // all fields set, unmapped offset included, back-to-back writes
    task automatic t_masks();
        for (int i = 0; i < 5; i++)
            wr(i[7:0], 8'hff);
        for (int i = 0; i < 5; i++)
            rdchk(i[7:0], MASK[i]);
        rdchk(8'hff, 8'h00);
        @(negedge ref_clk);
        check8({4'h0, spi_alt_o}, {4'h0, spi_out});
        check8({4'h0, spi_def_oe}, 8'h00);
        check8({4'h0, usart_in}, {4'h0, usart_alt_i});
        check8({6'h0, twi_alt_o}, {6'h0, twi_out});
        check8({6'h0, lut_def_pin}, 8'h00);
        check8({5'h0, event_pin_oe}, 8'h07);
        check8({2'h0, timer_a_alt_pin}, {5'h0, timer_a_wave[2:0]});
        @(posedge ref_clk);
        timer_a_split <= 1'b1;
        @(negedge ref_clk);
        check8({2'h0, timer_a_alt_oe}, {2'h0, timer_a_wave_en});
        check8({7'h0, timer_b_alt_pin}, {7'h0, timer_b_out});
        @(posedge ref_clk);
    endtask

    // one bit at a time in both timer modes, write then read at once
    task automatic t_bits();
        for (int s = 0; s < 2; s++)
        begin
            timer_a_split <= s[0];
            for (int r = 0; r < 4; r++)
                for (int b = 0; b < 8; b++)
                begin
                    wr(r[7:0], 8'h01 << b);
                    rdchk(r[7:0], (8'h01 << b) & MASK[r]);
                    repeat (2) @(posedge ref_clk);
                end
        end
    endtask

    initial
    begin
        t_reset();
        t_masks();
        t_bits();
        wr(8'h02, 8'h3f);
        rdchk(8'h02, 8'h3f);
        t_reset();
        complete_run();
    end

    initial
    begin
        #200_000;
        mismatches++;
        complete_run();
    end
endmodule

bind plmux_top plmux_props props (.*);
